// >>> hdl/cst_core.sv
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// RULE1: Time counted in machine cycles of two clocks
// RULE2: Store accumulator writes memory, sets N Z
// RULE3: Store index writes memory, sets N Z
// RULE4: Opcode 9B sets interrupt mask, two cycles
// RULE5: Test sets N Z, operand untouched
// RULE6: Short offset: one byte plus index
// RULE7: Long offset: two bytes plus index
// RULE8: Plain indexed: address is index, no bytes
// RULE9: Accumulator implied: no operand bytes fetched
// RULE10: Index implied: no operand bytes fetched
// RULE11: Index zero-extended, offset added unsigned, 16 bits
module cst_core
  import cst_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // Memory bus
  output cst_mem_t mem_o,
  input wire logic [7:0] mem_rdata_i
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [1:0] mode_bytes(input cst_mode_t m);
    case (m)
      DIRECT_MODE: mode_bytes = OPB_ONE;
      INDEXED_SHORT_OFFSET_MODE: mode_bytes = OPB_ONE;
      FULL_ADDRESS_MODE: mode_bytes = OPB_TWO;
      INDEXED_LONG_OFFSET_MODE: mode_bytes = OPB_TWO;
      default: mode_bytes = OPB_NONE;
    endcase
  endfunction : mode_bytes

  function automatic logic [2:0] mode_cycles(input cst_mode_t m);
    case (m)
      DIRECT_MODE: mode_cycles = MC_DIR;
      FULL_ADDRESS_MODE: mode_cycles = MC_FULL;
      INDEXED_PLAIN_MODE: mode_cycles = MC_PLAIN;
      INDEXED_SHORT_OFFSET_MODE: mode_cycles = MC_SHORT;
      INDEXED_LONG_OFFSET_MODE: mode_cycles = MC_LONG;
      default: mode_cycles = MC_IMPLIED;
    endcase
  endfunction : mode_cycles

  function automatic cst_dec_t decode(input logic [7:0] op);
    cst_dec_t d;
    d.kind = NO_OP;
    d.mode = NO_OPERAND_MODE;
    d.nb = OPB_NONE;
    d.cyc = MC_UNDEF;
    if (op == OP_SET_INT_MASK) begin
      d.kind = SET_INTERRUPT_MASK_OP;
    end else if (op[3:0] == OPL_STORE_ACC || op[3:0] == OPL_STORE_INDEX) begin
      d.kind = (op[3:0] == OPL_STORE_ACC) ? STORE_ACC_OP : STORE_INDEX_OP;
      case (op[7:4])
        OPH_ST_DIR: d.mode = DIRECT_MODE;
        OPH_ST_FULL: d.mode = FULL_ADDRESS_MODE;
        OPH_ST_PLAIN: d.mode = INDEXED_PLAIN_MODE;
        OPH_ST_SHORT: d.mode = INDEXED_SHORT_OFFSET_MODE;
        OPH_ST_LONG: d.mode = INDEXED_LONG_OFFSET_MODE;
        default: d.kind = NO_OP;
      endcase
    end else if (op[3:0] == OPL_TEST) begin
      d.kind = TEST_VALUE_OP;
      case (op[7:4])
        OPH_TS_ACC: d.mode = IMPLIED_ACCUMULATOR_MODE;
        OPH_TS_IDX: d.mode = IMPLIED_INDEX_MODE;
        OPH_TS_DIR: d.mode = DIRECT_MODE;
        OPH_TS_PLAIN: d.mode = INDEXED_PLAIN_MODE;
        OPH_TS_SHORT: d.mode = INDEXED_SHORT_OFFSET_MODE;
        default: d.kind = NO_OP;
      endcase
    end
    d.nb = mode_bytes(d.mode); // [RULE6] [RULE7] [RULE8] [RULE9] [RULE10]
    if (d.kind == SET_INTERRUPT_MASK_OP) begin
      d.cyc = MC_SEI; // [RULE4]
    end else if (d.kind != NO_OP) begin
      d.cyc = mode_cycles(d.mode); // [RULE2] [RULE3] [RULE5]
    end
    return d;
  endfunction : decode

  function automatic logic [15:0] eff_addr(input cst_mode_t m,
                                           input logic [7:0] x,
                                           input logic [15:0] o);
    case (m)
      DIRECT_MODE: eff_addr = {8'h00, o[7:0]};
      FULL_ADDRESS_MODE: eff_addr = o;
      INDEXED_PLAIN_MODE: eff_addr = {8'h00, x}; // [RULE8]
      INDEXED_SHORT_OFFSET_MODE: eff_addr = {8'h00, x} + {8'h00, o[7:0]}; // [RULE6] [RULE11]
      INDEXED_LONG_OFFSET_MODE: eff_addr = {8'h00, x} + o; // [RULE7] [RULE11]
      default: eff_addr = 16'h0000;
    endcase
  endfunction : eff_addr

  function automatic logic mem_mode(input cst_mode_t m);
    mem_mode = (m != NO_OPERAND_MODE) && (m != IMPLIED_ACCUMULATOR_MODE) &&
               (m != IMPLIED_INDEX_MODE);
  endfunction : mem_mode

  // Bus access for machine cycle k of an instruction
  function automatic cst_mem_t plan(input cst_dec_t d, input logic [2:0] k,
                                    input logic [15:0] pc,
                                    input logic [15:0] ea,
                                    input logic [7:0] wd);
    cst_mem_t m;
    m = '0;
    if (k <= {1'b0, d.nb}) begin
      m.rd = 1'b1;
      m.addr = pc;
    end else if ((d.kind == STORE_ACC_OP || d.kind == STORE_INDEX_OP) &&
                 k == d.cyc - 3'h1) begin
      m.wr = 1'b1; // [RULE2] [RULE3]
      m.addr = ea;
      m.wdata = wd;
    end else if (d.kind == TEST_VALUE_OP && mem_mode(d.mode) &&
                 k == {1'b0, d.nb} + 3'h1) begin
      m.rd = 1'b1;
      m.addr = ea;
    end
    return m;
  endfunction : plan

  // ****************************************
  // State
  // ****************************************
  cst_state_t s_r;
  cst_state_t s_nxt;
  logic bnd;
  logic fin;
  logic done;
  logic [ADDR_W-1:0] ea_apb;

  assign bnd = ce_i && s_r.ph;
  assign fin = bnd && s_r.fsm == EXECUTE && s_r.mc == s_r.dec.cyc - 3'h1;
  assign done = ce_i && psel_i && penable_i && s_r.ack;
  assign ea_apb = paddr_i;

  assign pready_o = s_r.ack && ce_i;
  assign prdata_o = s_r.prdata;
  assign pslverr_o = s_r.pslverr;
  assign mem_o = s_r.mem;

  always_comb begin
    cst_dec_t d;
    logic [15:0] opn;
    logic [15:0] pcn;
    logic [7:0] val;
    logic hit;
    logic busy_reg;
    d = s_r.dec;
    opn = s_r.opnd;
    pcn = s_r.pc;
    val = 8'h00;
    hit = 1'b0;
    busy_reg = 1'b0;
    s_nxt = s_r;
    if (ce_i) begin
      // ****************************************
      // APB slave, one wait state
      // ****************************************
      if (psel_i && penable_i && !s_r.ack) begin
        s_nxt.ack = 1'b1;
        s_nxt.prdata = 32'h0000_0000;
        case (ea_apb[11:0])
          ADDR_CTRL: begin
            hit = 1'b1;
            s_nxt.prdata[CTRL_RUN_BIT] = s_r.run;
          end
          ADDR_STATUS: begin
            hit = 1'b1;
            s_nxt.prdata[STATUS_BUSY_BIT] = s_r.fsm != HALTED;
            s_nxt.prdata[STATUS_UNDEF_BIT] = s_r.undef;
            s_nxt.prdata[STATUS_OPC_LSB +: 8] = s_r.last_opc;
            s_nxt.prdata[STATUS_CNT_LSB +: 16] = s_r.icnt;
          end
          ADDR_PC: begin
            hit = 1'b1;
            busy_reg = 1'b1;
            s_nxt.prdata[15:0] = s_r.pc;
          end
          ADDR_REGS: begin
            hit = 1'b1;
            busy_reg = 1'b1;
            s_nxt.prdata[REGS_ACC_LSB +: 8] = s_r.acc;
            s_nxt.prdata[REGS_IDX_LSB +: 8] = s_r.idx;
            s_nxt.prdata[REGS_FLAG_LSB +: 4] = s_r.flg;
          end
          default: hit = 1'b0;
        endcase
        // Core state is writable only while stopped and halted
        s_nxt.pslverr = !hit || (pwrite_i && busy_reg &&
                        (s_r.run || s_r.fsm != HALTED));
        if (!hit) begin
          s_nxt.prdata = 32'h0000_0000;
        end
      end
      if (done) begin
        s_nxt.ack = 1'b0;
        if (pwrite_i && !s_r.pslverr) begin
          case (ea_apb[11:0])
            ADDR_CTRL: begin
              if (pstrb_i[0]) s_nxt.run = pwdata_i[CTRL_RUN_BIT];
            end
            ADDR_STATUS: begin
              if (pstrb_i[0] && pwdata_i[STATUS_UNDEF_BIT]) s_nxt.undef = 1'b0;
            end
            ADDR_PC: begin
              if (pstrb_i[0]) s_nxt.pc[7:0] = pwdata_i[7:0];
              if (pstrb_i[1]) s_nxt.pc[15:8] = pwdata_i[15:8];
            end
            ADDR_REGS: begin
              if (pstrb_i[0]) s_nxt.acc = pwdata_i[REGS_ACC_LSB +: 8];
              if (pstrb_i[1]) s_nxt.idx = pwdata_i[REGS_IDX_LSB +: 8];
              if (pstrb_i[2]) s_nxt.flg = pwdata_i[REGS_FLAG_LSB +: 4];
            end
            default: s_nxt.ack = 1'b0;
          endcase
        end
      end

      // ****************************************
      // Core sequencer
      // ****************************************
      s_nxt.ph = ~s_r.ph; // [RULE1]
      if (bnd) begin
        s_nxt.mem = '0;
        case (s_r.fsm)
          HALTED: begin
            if (s_r.run) begin
              s_nxt.fsm = FETCH;
              s_nxt.mem.rd = 1'b1;
              s_nxt.mem.addr = s_r.pc;
            end
          end
          FETCH: begin
            d = decode(mem_rdata_i);
            pcn = s_r.pc + 16'h0001;
            s_nxt.dec = d;
            s_nxt.last_opc = mem_rdata_i;
            s_nxt.pc = pcn;
            s_nxt.opnd = 16'h0000;
            s_nxt.mc = 3'h1;
            s_nxt.fsm = EXECUTE;
            if (d.kind == NO_OP) s_nxt.undef = 1'b1;
            s_nxt.mem = plan(d, 3'h1, pcn,
                             eff_addr(d.mode, s_r.idx, 16'h0000),
                             (d.kind == STORE_ACC_OP) ? s_r.acc : s_r.idx);
          end
          EXECUTE: begin
            if (s_r.mc <= {1'b0, d.nb}) begin
              opn = {s_r.opnd[7:0], mem_rdata_i}; // [RULE6] [RULE7]
              pcn = s_r.pc + 16'h0001;
            end else if (s_r.mem.rd) begin
              s_nxt.dat = mem_rdata_i;
            end
            s_nxt.opnd = opn;
            s_nxt.pc = pcn;
            if (fin) begin
              case (d.kind)
                STORE_ACC_OP: val = s_r.acc; // [RULE2]
                STORE_INDEX_OP: val = s_r.idx; // [RULE3]
                TEST_VALUE_OP: begin
                  if (d.mode == IMPLIED_ACCUMULATOR_MODE) val = s_r.acc; // [RULE9]
                  else if (d.mode == IMPLIED_INDEX_MODE) val = s_r.idx; // [RULE10]
                  else val = s_r.dat; // [RULE5]
                end
                default: val = 8'h00;
              endcase
              if (d.kind == SET_INTERRUPT_MASK_OP) begin
                s_nxt.flg.i = 1'b1; // [RULE4]
              end else if (d.kind != NO_OP) begin
                s_nxt.flg.n = val[7]; // [RULE2] [RULE3] [RULE5]
                s_nxt.flg.z = val == 8'h00;
              end
              s_nxt.icnt = s_r.icnt + 16'h0001;
              s_nxt.mc = 3'h0;
              if (s_r.run) begin
                s_nxt.fsm = FETCH;
                s_nxt.mem.rd = 1'b1;
                s_nxt.mem.addr = pcn;
              end else begin
                s_nxt.fsm = HALTED;
              end
            end else begin
              s_nxt.mc = s_r.mc + 3'h1;
              s_nxt.mem = plan(d, s_r.mc + 3'h1, pcn,
                               eff_addr(d.mode, s_r.idx, opn),
                               (d.kind == STORE_ACC_OP) ? s_r.acc : s_r.idx);
            end
          end
          default: s_nxt.fsm = HALTED;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [4:0] hcnt;
  logic [15:0] spc;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hcnt <= 5'h00;
      spc <= 16'h0000;
    end else if (ce_i) begin
      hcnt <= (fin || s_r.fsm == HALTED) ? 5'h00 : hcnt + 5'h01;
      if (bnd && s_r.fsm == FETCH) spc <= s_r.pc;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_cycle_length: assert property ( // [RULE1]
    fin |-> hcnt == 5'(OSC_PER_MC) * {2'b00, s_r.dec.cyc} - 5'h01)
    else $error("instruction length wrong");
  a_store_acc_data: assert property ( // [RULE2]
    s_r.mem.wr && s_r.dec.kind == STORE_ACC_OP |-> s_r.mem.wdata == s_r.acc)
    else $error("store accumulator data wrong");
  a_store_flags: assert property ( // [RULE3]
    fin && s_r.dec.kind == STORE_INDEX_OP |=>
      s_r.flg.z == ($past(s_r.idx) == 8'h00) &&
      s_r.flg.n == $past(s_r.idx[7]) && s_r.flg.c == $past(s_r.flg.c))
    else $error("store index flags wrong");
  a_mask_set: assert property ( // [RULE4]
    fin && s_r.dec.kind == SET_INTERRUPT_MASK_OP |=>
      s_r.flg.i && $stable(s_r.flg[2:0]))
    else $error("interrupt mask not set");
  a_test_no_write: assert property ( // [RULE5]
    s_r.dec.kind == TEST_VALUE_OP && s_r.fsm == EXECUTE |-> !s_r.mem.wr)
    else $error("test wrote memory");
  a_short_addr: assert property ( // [RULE6]
    s_r.fsm == EXECUTE && s_r.dec.mode == INDEXED_SHORT_OFFSET_MODE &&
    s_r.mc > 3'h1 && (s_r.mem.rd || s_r.mem.wr) |->
      s_r.mem.addr == {8'h00, s_r.idx} + {8'h00, s_r.opnd[7:0]})
    else $error("short offset address wrong");
  a_long_addr: assert property ( // [RULE7] [RULE11]
    s_r.fsm == EXECUTE && s_r.dec.mode == INDEXED_LONG_OFFSET_MODE &&
    s_r.mem.wr |-> s_r.mem.addr == {8'h00, s_r.idx} + s_r.opnd)
    else $error("long offset address wrong");
  a_pc_advance: assert property ( // [RULE8]
    fin |-> s_r.pc == spc + 16'h0001 + {14'h0000, s_r.dec.nb})
    else $error("operand byte count wrong");
  a_implied_idle: assert property ( // [RULE9] [RULE10]
    s_r.fsm == EXECUTE && !mem_mode(s_r.dec.mode) |->
      !s_r.mem.rd && !s_r.mem.wr)
    else $error("implied mode used the bus");

  c_long_store: cover property (
    fin && s_r.dec.mode == INDEXED_LONG_OFFSET_MODE);
  c_short_test: cover property (
    fin && s_r.dec.kind == TEST_VALUE_OP &&
    s_r.dec.mode == INDEXED_SHORT_OFFSET_MODE);
  c_mask: cover property (fin && s_r.dec.kind == SET_INTERRUPT_MASK_OP);

endmodule : cst_core

// >>> pkg/cst_pkg.sv
package cst_pkg;

  // ****************************************
  // Timing base
  // ****************************************
  localparam int OSC_PER_MC = 2;

  // ****************************************
  // Opcode map
  // ****************************************
  localparam logic [7:0] OP_SET_INT_MASK = 8'h9b;
  localparam logic [3:0] OPL_STORE_ACC = 4'h7;
  localparam logic [3:0] OPL_STORE_INDEX = 4'hf;
  localparam logic [3:0] OPL_TEST = 4'hd;
  localparam logic [3:0] OPH_ST_DIR = 4'hb;
  localparam logic [3:0] OPH_ST_FULL = 4'hc;
  localparam logic [3:0] OPH_ST_LONG = 4'hd;
  localparam logic [3:0] OPH_ST_SHORT = 4'he;
  localparam logic [3:0] OPH_ST_PLAIN = 4'hf;
  localparam logic [3:0] OPH_TS_ACC = 4'h4;
  localparam logic [3:0] OPH_TS_IDX = 4'h5;
  localparam logic [3:0] OPH_TS_DIR = 4'h3;
  localparam logic [3:0] OPH_TS_PLAIN = 4'h7;
  localparam logic [3:0] OPH_TS_SHORT = 4'h6;

  // ****************************************
  // Machine cycles and operand bytes
  // ****************************************
  localparam logic [2:0] MC_SEI = 3'h2;
  localparam logic [2:0] MC_UNDEF = 3'h2;
  localparam logic [2:0] MC_IMPLIED = 3'h3;
  localparam logic [2:0] MC_DIR = 3'h4;
  localparam logic [2:0] MC_FULL = 3'h5;
  localparam logic [2:0] MC_PLAIN = 3'h4;
  localparam logic [2:0] MC_SHORT = 3'h5;
  localparam logic [2:0] MC_LONG = 3'h6;
  localparam logic [1:0] OPB_NONE = 2'h0;
  localparam logic [1:0] OPB_ONE = 2'h1;
  localparam logic [1:0] OPB_TWO = 2'h2;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PC = 12'h008;
  localparam logic [11:0] ADDR_REGS = 12'h00c;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_UNDEF_BIT = 1;
  localparam int STATUS_OPC_LSB = 8;
  localparam int STATUS_CNT_LSB = 16;
  localparam int REGS_ACC_LSB = 0;
  localparam int REGS_IDX_LSB = 8;
  localparam int REGS_FLAG_LSB = 16;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    NO_OP, STORE_ACC_OP, STORE_INDEX_OP, SET_INTERRUPT_MASK_OP, TEST_VALUE_OP
  } cst_kind_t;

  typedef enum logic [2:0] {
    NO_OPERAND_MODE, IMPLIED_ACCUMULATOR_MODE, IMPLIED_INDEX_MODE,
    DIRECT_MODE, FULL_ADDRESS_MODE, INDEXED_PLAIN_MODE,
    INDEXED_SHORT_OFFSET_MODE, INDEXED_LONG_OFFSET_MODE
  } cst_mode_t;

  typedef enum logic [1:0] {
    HALTED = 2'b00, FETCH = 2'b01, EXECUTE = 2'b11
  } cst_fsm_t;

  typedef struct packed {
    cst_kind_t kind;
    cst_mode_t mode;
    logic [1:0] nb;
    logic [2:0] cyc;
  } cst_dec_t;

  typedef struct packed {
    logic i;
    logic n;
    logic z;
    logic c;
  } cst_flags_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } cst_mem_t;

  typedef struct packed {
    cst_fsm_t fsm;
    logic ph;
    logic [2:0] mc;
    cst_dec_t dec;
    logic [15:0] pc;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [15:0] opnd;
    logic [7:0] dat;
    cst_flags_t flg;
    logic run;
    logic undef;
    logic [7:0] last_opc;
    logic [15:0] icnt;
    cst_mem_t mem;
    logic ack;
    logic [31:0] prdata;
    logic pslverr;
  } cst_state_t;

  localparam cst_state_t RST_STATE = '0;

endpackage : cst_pkg

// >>> verification/cst_mem_model.sv
`timescale 1ns/100ps
module cst_mem_model
  import cst_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Core memory bus
  input cst_mem_t mem_i,
  output logic [7:0] rdata_o
);
  // ****************************************
  // Byte store and access counters
  // ****************************************
  logic [7:0] mem [0:65535];
  int rd_cnt;
  int wr_cnt;
  logic [15:0] last_waddr;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
    rdata_o = 8'h00;
    rd_cnt = 0;
    wr_cnt = 0;
    last_waddr = 16'h0000;
  end

  // One-cycle synchronous read; released bus shows a toggling pattern
  always @(posedge clk_i) begin
    if (mem_i.rd === 1'b1) begin
      rdata_o <= mem[mem_i.addr];
      rd_cnt <= rd_cnt + 1;
    end else begin
      rdata_o <= ~rdata_o;
    end
    if (mem_i.wr === 1'b1) begin
      mem[mem_i.addr] <= mem_i.wdata;
      wr_cnt <= wr_cnt + 1;
      last_waddr <= mem_i.addr;
    end
  end
endmodule : cst_mem_model

// >>> verification/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import cst_pkg::*;
;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'h0;
  logic pready_o;
  logic [31:0] prdata_o;
  logic pslverr_o;
  cst_mem_t mem_o;
  logic [7:0] mem_rdata_i;
  int err_count = 0;
  int num_checks = 0;
  logic last_err = 1'b0;
  int cyc = 0;
  localparam logic [15:0] PRG = 16'h0400;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  cst_core u_cst_core (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .mem_o(mem_o), .mem_rdata_i(mem_rdata_i));
  cst_mem_model u_cst_mem_model (.clk_i(clk_i), .mem_i(mem_o),
    .rdata_o(mem_rdata_i));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang();
    err_count++;
    $display("MISMATCH at %0t: wait limit reached", $time);
    wrap_up();
  endtask : hang

  // ****************************************
  // APB master
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    pstrb_i <= wr ? 4'hf : 4'h0;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      n++;
      if (n > 50) hang();
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    last_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wait_fetch(input logic [15:0] a);
    int n;
    n = 0;
    do begin
      n++;
      if (n > 200) hang();
      @(posedge clk_i);
    end while (!(mem_o.rd === 1'b1 && mem_o.addr === a));
  endtask : wait_fetch

  // ****************************************
  // One instruction from halt to halt
  // ****************************************
  task automatic run_op(input logic [7:0] op, input logic [7:0] b1,
    input logic [7:0] b2, input int len, input int mc,
    input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    logic [15:0] ea;
    logic [7:0] v;
    logic [3:0] fi;
    logic [3:0] fe;
    logic [31:0] d;
    logic st;
    logic mr;
    int t0, r0, w0, n;
    case (op[7:4])
      4'hb, 4'h3: ea = {8'h00, b1};
      4'hc: ea = {b1, b2};
      4'hf, 4'h7: ea = {8'h00, x};
      4'he, 4'h6: ea = {8'h00, x} + {8'h00, b1};
      default: ea = {8'h00, x} + {b1, b2};
    endcase
    st = (op[3:0] == 4'h7) || (op[3:0] == 4'hf);
    mr = (op[3:0] == 4'hd) && (op[7:4] != 4'h4) && (op[7:4] != 4'h5);
    v = (op[3:0] == 4'hf || op[7:4] == 4'h5) ? x : (mr ? m : a);
    fi = {1'b0, ~v[7], ~(v == 8'h00), 1'b1};
    fe = {1'b0, v[7], v == 8'h00, 1'b1};
    if (op == OP_SET_INT_MASK) begin
      fi = 4'b0101;
      fe = 4'b1101;
    end
    for (int i = 0; i < 4; i++) begin
      u_cst_mem_model.mem[PRG + i] = 8'h00;
    end
    u_cst_mem_model.mem[PRG] = op;
    if (len > 1) u_cst_mem_model.mem[PRG + 1] = b1;
    if (len > 2) u_cst_mem_model.mem[PRG + 2] = b2;
    u_cst_mem_model.mem[ea] = st ? ~v : m;
    apb(1'b1, ADDR_REGS, {12'h000, fi, x, a}, d);
    apb(1'b1, ADDR_PC, {16'h0000, PRG}, d);
    apb(1'b1, ADDR_CTRL, 32'h1, d);
    wait_fetch(PRG);
    t0 = cyc;
    r0 = u_cst_mem_model.rd_cnt;
    w0 = u_cst_mem_model.wr_cnt;
    wait_fetch(PRG + len[15:0]);
    chk(cyc - t0, OSC_PER_MC * mc);
    chk(u_cst_mem_model.rd_cnt - r0, 2 * (len + mr));
    chk(u_cst_mem_model.wr_cnt - w0, st ? 2 : 0);
    apb(1'b1, ADDR_CTRL, 32'h0, d);
    n = 0;
    do begin
      n++;
      if (n > 50) hang();
      apb(1'b0, ADDR_STATUS, 32'h0, d);
    end while (d[STATUS_BUSY_BIT] !== 1'b0);
    apb(1'b0, ADDR_REGS, 32'h0, d);
    chk(d[19:0], {fe, x, a});
    chk(u_cst_mem_model.mem[ea], st ? v : m);
    if (st) chk(u_cst_mem_model.last_waddr, ea);
    $display("test %h done", op);
  endtask : run_op

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    int n;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    run_op(8'hb7, 8'h80, 8'h00, 2, 4, 8'h80, 8'h00, 8'h00);
    run_op(8'hc7, 8'h12, 8'h34, 3, 5, 8'h00, 8'h11, 8'h00);
    run_op(8'hf7, 8'h00, 8'h00, 1, 4, 8'h7f, 8'hf0, 8'h00);
    run_op(8'he7, 8'h20, 8'h00, 2, 5, 8'h01, 8'hf0, 8'h00);
    run_op(8'hd7, 8'hff, 8'hc0, 3, 6, 8'hff, 8'hf0, 8'h00);
    run_op(8'hbf, 8'h81, 8'h00, 2, 4, 8'h55, 8'h00, 8'h00);
    run_op(8'hcf, 8'h23, 8'h45, 3, 5, 8'h00, 8'h9c, 8'h00);
    run_op(8'hff, 8'h00, 8'h00, 1, 4, 8'h80, 8'h40, 8'h00);
    run_op(8'hef, 8'h7f, 8'h00, 2, 5, 8'h00, 8'hc1, 8'h00);
    run_op(8'hdf, 8'h01, 8'h00, 3, 6, 8'h33, 8'hff, 8'h00);
    run_op(8'h4d, 8'h00, 8'h00, 1, 3, 8'h00, 8'h80, 8'h00);
    run_op(8'h5d, 8'h00, 8'h00, 1, 3, 8'h01, 8'h80, 8'h00);
    run_op(8'h3d, 8'h90, 8'h00, 2, 4, 8'h80, 8'h01, 8'h00);
    run_op(8'h7d, 8'h00, 8'h00, 1, 4, 8'h00, 8'hf8, 8'h80);
    run_op(8'h6d, 8'h10, 8'h00, 2, 5, 8'h80, 8'hf8, 8'h42);
    run_op(8'h9b, 8'h00, 8'h00, 1, 2, 8'h12, 8'h34, 8'h00);
    // Refused accesses and sticky undefined-opcode flag
    apb(1'b1, 12'h010, 32'h1, d);
    chk(last_err, 1'b1);
    chk(d, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1, d);
    apb(1'b1, ADDR_PC, 32'h0, d);
    chk(last_err, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h0, d);
    n = 0;
    do begin
      n++;
      if (n > 50) hang();
      apb(1'b0, ADDR_STATUS, 32'h0, d);
    end while (d[STATUS_BUSY_BIT] !== 1'b0);
    chk(d[STATUS_UNDEF_BIT], 1'b1);
    chk(last_err, 1'b0);
    apb(1'b1, ADDR_STATUS, 32'h2, d);
    apb(1'b0, ADDR_STATUS, 32'h0, d);
    chk(d[STATUS_UNDEF_BIT], 1'b0);
    $display("test register access done");
    wrap_up();
  end
endmodule : tb_top
